// ### rtl/npr_prot_regs.sv
// file: protection and option register block of the nonvolatile memory controller
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////////////////////////////////////
// How it works
// - program-flash protection register only takes writes that add protection.
// - writes encoding a non-allowed scenario transition are dropped whole.
// - program-flash protection readback equals the scenario being enforced.
// - from scenario 7 every target scenario 0 to 7 is accepted.
// - eeprom size field only accepts equal or larger values.
// - eeprom open bit may go 1 to 0 only, never back.
// - eeprom bit 7 clear protects the sized range, set disables protection.
// - with eeprom open bit set the size field is ignored, nothing protected.
// - eeprom range starts 0x100000, spans (size+1)*32 bytes.
// - eeprom open and size load from config byte 0xfffe0d at reset.
// - double-bit fault on eeprom byte clears open and sets all size bits.
// - program or erase to protected eeprom is refused and sets violation flag.
// - eeprom block erase refused while any eeprom sector is protected.
// - all option register bits readable, writes ignored.
// - option register loads from config byte 0xfffe0e at reset.
// - double-bit fault on option byte sets every option bit.
// - option bits go out to system logic with no protection meaning.
// - factory test register reads zero and ignores writes.
// - operation-enable bit picks protected or unprotected meaning of disable bits.
// - high and low size fields writable only while their disable bit is set.
// - program-flash protection loads from config byte 0xfffe0c at reset.
module npr_prot_regs
    import npr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // configuration field reads during the reset sequence
    output logic             cfg_rd_req,
    output logic      [23:0] cfg_rd_addr,
    input  wire logic        cfg_rd_valid,
    input  wire logic [7:0]  cfg_rd_data,
    input  wire logic        cfg_rd_dbl_fault,
    // granted commands to the flash engine
    output logic             cmd_start,
    output logic      [1:0]  cmd_kind,
    output logic      [23:0] cmd_addr,
    // option bits to system logic
    output logic      [7:0]  option_bits,
    output logic             cfg_loaded
);

    typedef struct packed {
        npr_fsm_type  fsm;
        logic [7:0]   pflash_protect;
        logic [7:0]   eeprom_protect;
        logic [7:0]   flash_option;
        logic         viol;
        logic         ack;
        logic [31:0]  rdata;
        logic [23:0]  cfg_addr;
        logic         cmd_go;
        logic [1:0]   cmd_kind;
        logic [23:0]  cmd_addr;
    } npr_state_type;

    npr_state_type state_r;
    npr_state_type state_nxt;

    //////////////////////////////////////////////////////////////////////////////////////////////////////////
    // protection decode

    function automatic logic pf_is_protected(input logic [7:0] pr, input logic [23:0] a);
        logic in_h;
        logic in_l;
        logic hit;
        in_h = (a >= NPR_PF_HIGH_START[pr[NPR_PF_HS_LSB +: 2]]);
        in_l = (a >= NPR_PF_LOW_BASE) && (a <= NPR_PF_LOW_END[pr[NPR_PF_LS_LSB +: 2]]);
        hit  = (!pr[NPR_PF_HDIS_BIT] && in_h) || (!pr[NPR_PF_LDIS_BIT] && in_l);
        // set: enabled ranges are protected; clear: enabled ranges are the only open ones
        return pr[NPR_PF_OPEN_BIT] ? hit : !hit;
    endfunction : pf_is_protected

    function automatic logic ee_is_protected(input logic [7:0] pr, input logic [23:0] a);
        logic [23:0] ofs;
        logic        in_ee;
        ofs   = a - NPR_EE_BASE;
        in_ee = (a >= NPR_EE_BASE) && (a <= NPR_EE_END);
        if (pr[NPR_EE_OPEN_BIT]) begin
            return 1'b0;
        end
        // offset in 32-byte steps against the size code, end step included
        return in_ee && (ofs[11:NPR_EE_STEP_LSB] <= pr[6:0]);
    endfunction : ee_is_protected

    function automatic logic [2:0] pf_scenario(input logic [7:0] pr);
        return {pr[NPR_PF_OPEN_BIT], pr[NPR_PF_HDIS_BIT], pr[NPR_PF_LDIS_BIT]};
    endfunction : pf_scenario

    //////////////////////////////////////////////////////////////////////////////////////////////////////////
    // next state

    // bus request decode
    logic        req;
    logic        hit_take;
    logic        wr_take;
    logic        lane0;
    logic [7:0]  wbyte;

    // protection write checks
    logic [2:0]  scn_cur;
    logic [2:0]  scn_new;
    logic [7:0]  pf_cand;
    logic        pf_ok;
    logic        ee_ok;

    // command checks
    logic [1:0]  wkind;
    logic [23:0] waddr;
    logic        in_pf;
    logic        in_ee;
    logic        ee_any;
    logic        pf_any;
    logic        cmd_ok;
    logic        refuse;

    // status flag and configuration load
    logic        viol_set;
    logic        viol_clr;
    logic [7:0]  cfg_val;

    always_comb begin
        state_nxt = state_r;
        state_nxt.cmd_go = 1'b0;
        state_nxt.ack    = 1'b0;

        req      = avs_read || avs_write;
        // bus answers only once configuration is in, and on the second edge of a request
        hit_take = req && !state_r.ack && (state_r.fsm == NPR_ST_RUN);
        wr_take  = avs_write && state_r.ack;
        lane0    = avs_byteenable[0];
        wbyte    = avs_writedata[7:0];

        scn_cur  = pf_scenario(state_r.pflash_protect);
        scn_new  = pf_scenario(wbyte);
        pf_cand  = state_r.pflash_protect;
        pf_cand[NPR_PF_OPEN_BIT] = wbyte[NPR_PF_OPEN_BIT];
        pf_cand[NPR_PF_HDIS_BIT] = wbyte[NPR_PF_HDIS_BIT];
        pf_cand[NPR_PF_LDIS_BIT] = wbyte[NPR_PF_LDIS_BIT];
        if (state_r.pflash_protect[NPR_PF_HDIS_BIT]) begin
            pf_cand[NPR_PF_HS_LSB +: 2] = wbyte[NPR_PF_HS_LSB +: 2];
        end
        if (state_r.pflash_protect[NPR_PF_LDIS_BIT]) begin
            pf_cand[NPR_PF_LS_LSB +: 2] = wbyte[NPR_PF_LS_LSB +: 2];
        end

        // a refused scenario change keeps every bit, size fields included
        pf_ok = lane0 && NPR_SCN_ALLOWED[scn_cur][scn_new];

        // equal size is no change, so it is let through with a legal open-bit write
        ee_ok = !(wbyte[NPR_EE_OPEN_BIT] && !state_r.eeprom_protect[NPR_EE_OPEN_BIT])
             && (wbyte[6:0] >= state_r.eeprom_protect[6:0]);

        wkind  = avs_writedata[NPR_CMD_KIND_LSB +: 2];
        waddr  = avs_writedata[NPR_CMD_ADDR_W-1:0];
        in_pf  = (waddr >= NPR_PF_BASE);
        in_ee  = (waddr >= NPR_EE_BASE) && (waddr <= NPR_EE_END);
        // any protected sector blocks a whole-array erase
        ee_any = !state_r.eeprom_protect[NPR_EE_OPEN_BIT];
        pf_any = (scn_cur != 3'h7);
        cmd_ok = (avs_byteenable == 4'hf) && (wkind != NPR_CMD_NONE);
        refuse = 1'b0;
        if (wkind == NPR_CMD_BLOCK_ERASE) begin
            if (in_ee) begin
                refuse = ee_any;
            end else if (in_pf) begin
                refuse = pf_any;
            end
        end else if (wkind != NPR_CMD_NONE) begin
            refuse = ee_is_protected(state_r.eeprom_protect, waddr)
                  || (in_pf && pf_is_protected(state_r.pflash_protect, waddr));
        end

        viol_set = 1'b0;
        viol_clr = 1'b0;

        if (hit_take) begin
            state_nxt.ack = 1'b1;
            // read data are registered here and stand until the next read or write
            case (avs_address)
                NPR_OFS_PFLASH_PROT: begin
                    state_nxt.rdata = {24'h000000, state_r.pflash_protect};
                end
                NPR_OFS_EEPROM_PROT: begin
                    state_nxt.rdata = {24'h000000, state_r.eeprom_protect};
                end
                NPR_OFS_FLASH_OPTION: begin
                    state_nxt.rdata = {24'h000000, state_r.flash_option};
                end
                NPR_OFS_FLASH_STATUS: begin
                    state_nxt.rdata = 32'h00000000;
                    state_nxt.rdata[NPR_ST_VIOL_BIT]   = state_r.viol;
                    // the bus is only answered after the load, so this bit reads one
                    state_nxt.rdata[NPR_ST_LOADED_BIT] = 1'b1;
                end
                NPR_OFS_COMMAND: begin
                    // last granted command, not the last attempt
                    state_nxt.rdata = {state_r.cmd_kind, 6'h00, state_r.cmd_addr};
                end
                default: begin
                    state_nxt.rdata = 32'h00000000;
                end
            endcase
        end

        if (wr_take) begin
            case (avs_address)
                NPR_OFS_PFLASH_PROT: begin
                    if (pf_ok) begin
                        state_nxt.pflash_protect = pf_cand;
                    end
                end
                NPR_OFS_EEPROM_PROT: begin
                    if (lane0 && ee_ok) begin
                        state_nxt.eeprom_protect = wbyte;
                    end
                end
                NPR_OFS_FLASH_STATUS: begin
                    // write one to clear; a violation in the same cycle wins below
                    viol_clr = lane0 && wbyte[NPR_ST_VIOL_BIT];
                end
                NPR_OFS_COMMAND: begin
                    if (cmd_ok) begin
                        if (refuse) begin
                            viol_set = 1'b1;
                        end else begin
                            state_nxt.cmd_go   = 1'b1;
                            state_nxt.cmd_kind = wkind;
                            state_nxt.cmd_addr = waddr;
                        end
                    end
                end
                NPR_OFS_FLASH_OPTION: begin
                    // loaded at reset only; software never reaches the option byte
                    state_nxt.flash_option = state_r.flash_option;
                end
                NPR_OFS_FACTORY_TEST: begin
                    state_nxt.viol = state_r.viol;
                end
                default: begin
                    // unmapped offsets take the write and drop it
                    state_nxt.viol = state_r.viol;
                end
            endcase
        end

        // a violation in the same cycle as its clear is kept
        if (viol_set) begin
            state_nxt.viol = 1'b1;
        end else if (viol_clr) begin
            state_nxt.viol = 1'b0;
        end

        //////////////////////////////////////////////////////////////////////////////////////////////////////
        // reset-time configuration load

        // one byte per valid edge in fixed order; bytes may come back to back
        cfg_val = cfg_rd_data;

        case (state_r.fsm)
            NPR_ST_LOAD_PF: begin
                if (cfg_rd_valid) begin
                    cfg_val = cfg_rd_dbl_fault ? NPR_PF_FAULT_VAL : cfg_rd_data;
                    state_nxt.pflash_protect = cfg_val;
                    state_nxt.cfg_addr       = NPR_CFG_EEPROM_ADDR;
                    state_nxt.fsm            = NPR_ST_LOAD_EE;
                end
            end
            NPR_ST_LOAD_EE: begin
                if (cfg_rd_valid) begin
                    cfg_val = cfg_rd_dbl_fault ? NPR_EE_FAULT_VAL : cfg_rd_data;
                    state_nxt.eeprom_protect = cfg_val;
                    state_nxt.cfg_addr       = NPR_CFG_OPTION_ADDR;
                    state_nxt.fsm            = NPR_ST_LOAD_OP;
                end
            end
            NPR_ST_LOAD_OP: begin
                if (cfg_rd_valid) begin
                    cfg_val = cfg_rd_dbl_fault ? NPR_OPT_FAULT_VAL : cfg_rd_data;
                    state_nxt.flash_option = cfg_val;
                    state_nxt.fsm          = NPR_ST_RUN;
                end
            end
            NPR_ST_RUN: begin
                state_nxt.fsm = NPR_ST_RUN;
            end
            default: begin
                state_nxt.fsm      = NPR_ST_LOAD_PF;
                state_nxt.cfg_addr = NPR_CFG_PFLASH_ADDR;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // fully protected until the configuration field has been read
            state_r.fsm            <= NPR_ST_LOAD_PF;
            state_r.pflash_protect <= NPR_PF_FAULT_VAL;
            state_r.eeprom_protect <= NPR_EE_FAULT_VAL;
            state_r.flash_option   <= NPR_OPT_FAULT_VAL;
            state_r.viol           <= 1'b0;
            state_r.ack            <= 1'b0;
            state_r.rdata          <= 32'h00000000;
            state_r.cfg_addr       <= NPR_CFG_PFLASH_ADDR;
            state_r.cmd_go         <= 1'b0;
            state_r.cmd_kind       <= NPR_CMD_NONE;
            state_r.cmd_addr       <= 24'h000000;
        end else begin
            state_r <= state_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////////////
    // outputs

    // limitation: bus stalls in waitrequest until all three configuration bytes are in
    // waitrequest is combinational, so the single wait state costs no extra flop
    assign avs_waitrequest = (avs_read || avs_write) && !state_r.ack;
    assign avs_readdata    = state_r.rdata;
    assign cfg_rd_req      = (state_r.fsm != NPR_ST_RUN);
    assign cfg_rd_addr     = state_r.cfg_addr;
    assign cmd_start       = state_r.cmd_go;
    assign cmd_kind        = state_r.cmd_kind;
    assign cmd_addr        = state_r.cmd_addr;
    assign option_bits     = state_r.flash_option;
    assign cfg_loaded      = (state_r.fsm == NPR_ST_RUN);

endmodule : npr_prot_regs

// ### rtl/npr_pkg.sv
// package: register map, field layout, reset-time load values and command codes
package npr_pkg;

    // avalon byte offsets, one aligned word each
    localparam logic [4:0]  NPR_OFS_PFLASH_PROT  = 5'h00;
    localparam logic [4:0]  NPR_OFS_EEPROM_PROT  = 5'h04;
    localparam logic [4:0]  NPR_OFS_FLASH_OPTION = 5'h08;
    localparam logic [4:0]  NPR_OFS_FACTORY_TEST = 5'h0c;
    localparam logic [4:0]  NPR_OFS_FLASH_STATUS = 5'h10;
    localparam logic [4:0]  NPR_OFS_COMMAND      = 5'h14;

    // program-flash protection fields
    localparam int          NPR_PF_OPEN_BIT      = 7;
    localparam int          NPR_PF_RSVD_BIT      = 6;
    localparam int          NPR_PF_HDIS_BIT      = 5;
    localparam int          NPR_PF_HS_LSB        = 3;
    localparam int          NPR_PF_LDIS_BIT      = 2;
    localparam int          NPR_PF_LS_LSB        = 0;

    // eeprom protection fields
    localparam int          NPR_EE_OPEN_BIT      = 7;

    // flash status fields
    localparam int          NPR_ST_VIOL_BIT      = 0;
    localparam int          NPR_ST_LOADED_BIT    = 7;

    // command word fields
    localparam int          NPR_CMD_KIND_LSB     = 30;
    localparam int          NPR_CMD_ADDR_W       = 24;

    localparam logic [1:0]  NPR_CMD_NONE         = 2'h0;
    localparam logic [1:0]  NPR_CMD_PROGRAM      = 2'h1;
    localparam logic [1:0]  NPR_CMD_SECTOR_ERASE = 2'h2;
    localparam logic [1:0]  NPR_CMD_BLOCK_ERASE  = 2'h3;

    // configuration field addresses read during the reset sequence
    localparam logic [23:0] NPR_CFG_PFLASH_ADDR  = 24'hfffe0c;
    localparam logic [23:0] NPR_CFG_EEPROM_ADDR  = 24'hfffe0d;
    localparam logic [23:0] NPR_CFG_OPTION_ADDR  = 24'hfffe0e;

    // values forced on a double-bit fault, also held until the load completes
    localparam logic [7:0]  NPR_PF_FAULT_VAL     = 8'h7f;
    localparam logic [7:0]  NPR_EE_FAULT_VAL     = 8'h7f;
    localparam logic [7:0]  NPR_OPT_FAULT_VAL    = 8'hff;

    // address map of the two arrays
    localparam logic [23:0] NPR_EE_BASE          = 24'h100000;
    localparam logic [23:0] NPR_EE_END           = 24'h100fff;
    localparam int          NPR_EE_STEP_LSB      = 5;
    localparam logic [23:0] NPR_PF_BASE          = 24'hfe0000;
    localparam logic [23:0] NPR_PF_LOW_BASE      = 24'hff8000;

    // high range start and low range end per size code
    localparam logic [23:0] NPR_PF_HIGH_START [4] = '{24'hfff800, 24'hfff000, 24'hffe000, 24'hffc000};
    localparam logic [23:0] NPR_PF_LOW_END    [4] = '{24'hff83ff, 24'hff87ff, 24'hff8fff, 24'hff9fff};

    // scenario = {open, high disable, low disable}; bit n of row m: m -> n allowed
    localparam logic [7:0]  NPR_SCN_ALLOWED   [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08,
                                                      8'h18, 8'h38, 8'h58, 8'hff};

    typedef enum logic [3:0] {
        NPR_ST_LOAD_PF = 4'b0001,
        NPR_ST_LOAD_EE = 4'b0010,
        NPR_ST_LOAD_OP = 4'b0100,
        NPR_ST_RUN     = 4'b1000
    } npr_fsm_type;

endpackage : npr_pkg

// ### test/npr_prot_regs_assertions.sv
// checker: port-level properties of the protection and option register block
`timescale 1ns/1ps

module npr_prot_regs_assertions (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        cfg_rd_valid,
    input wire logic [23:0] cfg_rd_addr,
    input wire logic [7:0]  cfg_rd_data,
    input wire logic        cfg_rd_dbl_fault,
    input wire logic        cmd_start,
    input wire logic [7:0]  option_bits,
    input wire logic        cfg_loaded
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    //////////////////////////////////////////////////////////////////////////////////////////////////////////////
    sequence pf_byte_taken;
        cfg_rd_valid && !cfg_loaded && cfg_rd_addr == 24'hfffe0c;
    endsequence
    sequence ee_byte_taken;
        cfg_rd_valid && !cfg_loaded && cfg_rd_addr == 24'hfffe0d;
    endsequence
    sequence opt_clean_taken;
        cfg_rd_valid && !cfg_loaded && cfg_rd_addr == 24'hfffe0e && !cfg_rd_dbl_fault;
    endsequence
    sequence opt_fault_taken;
        cfg_rd_valid && !cfg_loaded && cfg_rd_addr == 24'hfffe0e && cfg_rd_dbl_fault;
    endsequence
    sequence cmd_accepted;
        avs_write && !avs_waitrequest && avs_address == 5'h14;
    endsequence

    //////////////////////////////////////////////////////////////////////////////////////////////////////////////
    a_pf_then_ee: assert property (pf_byte_taken |=> cfg_rd_addr == 24'hfffe0d)
        else $error("load did not move from the pflash byte to the eeprom byte");
    a_ee_then_opt: assert property (ee_byte_taken |=> cfg_rd_addr == 24'hfffe0e)
        else $error("load did not move from the eeprom byte to the option byte");
    a_option_load: assert property (opt_clean_taken |=> option_bits == $past(cfg_rd_data) && cfg_loaded)
        else $error("option bits do not match the loaded byte");
    a_option_fault: assert property (opt_fault_taken |=> option_bits == 8'hff)
        else $error("option bits not all set after a double fault");
    a_option_frozen: assert property (cfg_loaded && $past(cfg_loaded) |-> $stable(option_bits))
        else $error("option bits changed after the load");
    a_option_readback: assert property (avs_read && !avs_waitrequest && avs_address == 5'h08 |->
                                        avs_readdata == {24'h000000, option_bits})
        else $error("option register read differs from option bits");
    a_factory_zero: assert property (avs_read && !avs_waitrequest && avs_address == 5'h0c |-> avs_readdata == 32'h0)
        else $error("factory test register read nonzero");
    // registers hold reset values until loaded, so no access may complete early
    a_stall_unloaded: assert property ((avs_read || avs_write) && !cfg_loaded |-> avs_waitrequest)
        else $error("bus access answered before the configuration load");
    a_grant_cause: assert property (cmd_start |-> $past(avs_write && !avs_waitrequest && avs_address == 5'h14))
        else $error("command granted without an accepted command write");
    a_grant_pulse: assert property (cmd_accepted ##1 cmd_start |=> !cmd_start)
        else $error("grant pulse longer than one cycle");
endmodule : npr_prot_regs_assertions

bind npr_prot_regs npr_prot_regs_assertions npr_prot_regs_assertions_inst (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cfg_rd_valid(cfg_rd_valid),
    .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data), .cfg_rd_dbl_fault(cfg_rd_dbl_fault),
    .cmd_start(cmd_start), .option_bits(option_bits), .cfg_loaded(cfg_loaded));

// ### test/tb_npr_prot_regs.sv
// testbench: register bus sequences against the protection and option register block
`timescale 1ns/1ps

module tb_npr_prot_regs;
    import npr_pkg::*;

    logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest, cfg_rd_req, cfg_rd_valid;
    logic        cfg_rd_dbl_fault, cmd_start, cfg_loaded, last_start;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic [23:0] cfg_rd_addr, cmd_addr;
    logic [7:0]  cfg_rd_data, option_bits;
    logic [1:0]  cmd_kind;
    int          n_fail, n_checks, cycles;

    npr_prot_regs npr_prot_regs_inst (
        .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cfg_rd_req(cfg_rd_req), .cfg_rd_addr(cfg_rd_addr),
        .cfg_rd_valid(cfg_rd_valid), .cfg_rd_data(cfg_rd_data), .cfg_rd_dbl_fault(cfg_rd_dbl_fault),
        .cmd_start(cmd_start), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .option_bits(option_bits),
        .cfg_loaded(cfg_loaded));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // whole run is about 1650 cycles; a hang stops far beyond that
    always @(posedge clk) begin
        cycles++;
        if (cycles > 8000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %b, seen %b", nm, e, g);
        end
    endtask : chk_bit

    // one avalon transfer; entered and left just after a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        #1;
        // waitrequest is looked at settled, never in the time step of the edge
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
            #1;
            n++;
        end
        // low in a settled cycle, so the coming edge completes the transfer
        @(posedge clk);
        q = avs_readdata;
        chk("wait_states", 32'd1, 32'(n));
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        #1;
        last_start = cmd_start;
        @(posedge clk);
    endtask : bus

    task automatic wr_rd(input logic [4:0] a, input logic [7:0] d, input logic [7:0] e, input string nm);
        logic [31:0] q;
        bus(1'b1, a, {24'h000000, d}, q);
        bus(1'b0, a, 32'h0, q);
        chk(nm, {24'h000000, e}, q);
    endtask : wr_rd

    // reset, then feed the three configuration bytes with a read already waiting
    task automatic boot(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input logic flt);
        logic [7:0]  b [3];
        logic [31:0] q;
        b = '{b0, b1, b2};
        sys_rst <= 1'b1;
        repeat (5) @(posedge clk);
        sys_rst     <= 1'b0;
        avs_read    <= 1'b1;
        avs_address <= 5'h08;
        for (int i = 0; i < 3; i++) begin
            cfg_rd_valid     <= 1'b1;
            cfg_rd_data      <= b[i];
            cfg_rd_dbl_fault <= flt;
            #1;
            chk("cfg_rd_addr", 32'h00fffe0c + 32'(i), {8'h00, cfg_rd_addr});
            chk_bit("cfg_rd_req", 1'b1, cfg_rd_req);
            @(posedge clk);
        end
        cfg_rd_valid <= 1'b0;
        bus(1'b0, 5'h08, 32'h0, q);
        chk("flash_option", {24'h000000, flt ? 8'hff : b2}, q);
        chk_bit("cfg_loaded", 1'b1, cfg_loaded);
        chk_bit("cfg_rd_req", 1'b0, cfg_rd_req);
        chk("option_bits", {24'h000000, flt ? 8'hff : b2}, {24'h000000, option_bits});
        bus(1'b0, 5'h00, 32'h0, q);
        chk("pflash_protect", {24'h000000, flt ? 8'h7f : b0}, q);
        bus(1'b0, 5'h04, 32'h0, q);
        chk("eeprom_protect", {24'h000000, flt ? 8'h7f : b1}, q);
    endtask : boot

    task automatic cmd(input logic [1:0] k, input logic [23:0] a, input logic grant);
        logic [31:0] q;
        bus(1'b1, 5'h14, {k, 6'h00, a}, q);
        chk_bit("cmd_start", grant, last_start);
        if (grant)
            chk("cmd_target", {6'h00, k, a}, {6'h00, cmd_kind, cmd_addr});
        bus(1'b0, 5'h10, 32'h0, q);
        chk_bit("violation", ~grant, q[0]);
        chk_bit("loaded", 1'b1, q[7]);
        bus(1'b1, 5'h10, 32'h1, q);
    endtask : cmd

    // scenario index {open, high disable, low disable}, both size fields 01, reserved bit set
    function automatic logic [7:0] enc(input logic [2:0] s);
        return {s[2], 1'b1, s[1], 2'b01, s[0], 2'b01};
    endfunction : enc

    //////////////////////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        n_fail = 0;
        n_checks = 0;
        cycles = 0;
        sys_rst = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        cfg_rd_valid = 1'b0;
        cfg_rd_data = 8'h00;
        cfg_rd_dbl_fault = 1'b0;
        @(posedge clk);
        for (int m = 0; m < 8; m++) begin
            for (int k = 0; k < 8; k++) begin
                boot(enc(3'(m)), 8'h83, 8'ha5, 1'b0);
                wr_rd(5'h00, enc(3'(k)), NPR_SCN_ALLOWED[m][k] ? enc(3'(k)) : enc(3'(m)), "pflash_scn");
            end
        end
        boot(8'hed, 8'h83, 8'ha5, 1'b0);
        wr_rd(5'h08, 8'h00, 8'ha5, "flash_option");
        wr_rd(5'h0c, 8'hff, 8'h00, "factory_test");
        wr_rd(5'h18, 8'hff, 8'h00, "unmapped");
        wr_rd(5'h00, 8'hfd, 8'hfd, "pflash_size");
        wr_rd(5'h00, 8'hdd, 8'hdd, "pflash_size");
        wr_rd(5'h00, 8'hc5, 8'hdd, "pflash_size");
        cmd(NPR_CMD_PROGRAM, 24'hffc000, 1'b0);
        cmd(NPR_CMD_PROGRAM, 24'hff8000, 1'b1);
        cmd(NPR_CMD_BLOCK_ERASE, 24'hfe0000, 1'b0);
        cmd(NPR_CMD_PROGRAM, 24'h100000, 1'b1);
        cmd(NPR_CMD_BLOCK_ERASE, 24'h100000, 1'b1);
        wr_rd(5'h04, 8'h82, 8'h83, "eeprom_protect");
        wr_rd(5'h04, 8'h05, 8'h05, "eeprom_protect");
        wr_rd(5'h04, 8'h86, 8'h05, "eeprom_protect");
        wr_rd(5'h04, 8'h05, 8'h05, "eeprom_protect");
        wr_rd(5'h04, 8'h06, 8'h06, "eeprom_protect");
        cmd(NPR_CMD_PROGRAM, 24'h1000df, 1'b0);
        cmd(NPR_CMD_SECTOR_ERASE, 24'h1000e0, 1'b1);
        cmd(NPR_CMD_BLOCK_ERASE, 24'h100000, 1'b0);
        boot(8'h12, 8'h34, 8'h56, 1'b1);
        cmd(NPR_CMD_SECTOR_ERASE, 24'h100fff, 1'b0);
        give_verdict();
    end
endmodule : tb_npr_prot_regs
